/* File: verilog/tck_defines.svh */
// offsets, field positions, reset values and divide counts of the tick counter
`ifndef TCK_DEFINES_SVH
`define TCK_DEFINES_SVH

`define TCK_ADDR_W 8
`define TCK_SC_OFS 8'h00
`define TCK_LIMIT_OFS 8'h04
`define TCK_COUNT_OFS 8'h08

`define TCK_SRC_HI 15
`define TCK_SRC_LO 14
`define TCK_PS_HI 10
`define TCK_PS_LO 8
`define TCK_FLAG_BIT 7
`define TCK_IE_BIT 6
`define TCK_TOE_BIT 4

`define TCK_LIMIT_RST 16'h0000
`define TCK_COUNT_RST 16'h0000
`define TCK_PS_OFF 3'h0

`define TCK_DIV_W 11
`define TCK_BIN_BASE 11'h001
`define TCK_ALT_BASE 11'h080
`define TCK_DIV_100 11'h064
`define TCK_DIV_1000 11'h3e8

`endif

/* File: verilog/tck_pkg.sv */
// types shared by the tick counter files
package tck_pkg;

   typedef enum logic [1:0] {
      TCK_SRC_XTAL = 2'h0,
      TCK_SRC_LOWPWR = 2'h1,
      TCK_SRC_IREF = 2'h2,
      TCK_SRC_BUS = 2'h3
   } tck_src_e;

   typedef logic [2:0] tck_ps_t;
   typedef logic [15:0] tck_count_t;

endpackage

/* File: verilog/tck_edge_sync.sv */
// two-flop synchronisers with rising edge pulses for the source clock pins
`timescale 1ns/1ps
module tck_edge_sync (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [2:0] pinIn,
   output logic [2:0] risePulse
);

   logic [2:0] meta_r;
   logic [2:0] sync_r;
   logic [2:0] last_r;

   genvar i;
   generate
      for (i = 0; i < 3; i = i + 1) begin : g_sync
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               meta_r[i] <= 1'b0;
               sync_r[i] <= 1'b0;
               last_r[i] <= 1'b0;
            end else begin
               meta_r[i] <= pinIn[i];
               sync_r[i] <= meta_r[i];
               last_r[i] <= sync_r[i];
            end
         end
         assign risePulse[i] = sync_r[i] & ~last_r[i];
      end
   endgenerate

endmodule

/* File: verilog/tck_prescaler.sv */
// prescaler: divides source ticks by the selected binary or decimal value
`timescale 1ns/1ps
`include "tck_defines.svh"
module tck_prescaler (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic srcTick,
   input wire logic clear,
   input wire logic altDiv,
   input wire tck_pkg::tck_ps_t psSel,
   output logic stepOut
);
   import tck_pkg::*;

   logic [`TCK_DIV_W-1:0] preCnt_r;
   logic [`TCK_DIV_W-1:0] termCnt;
   logic stepOut_r;

   // terminal count is divide value minus one
   always_comb begin
      termCnt = '0;
      if (!altDiv) begin
         if (psSel != `TCK_PS_OFF)
            termCnt = (`TCK_BIN_BASE << (psSel - 3'h1)) - `TCK_BIN_BASE;
      end else begin
         unique case (psSel)
            3'h6: termCnt = `TCK_DIV_100 - `TCK_BIN_BASE;
            3'h7: termCnt = `TCK_DIV_1000 - `TCK_BIN_BASE;
            3'h0: termCnt = '0;
            default: termCnt = (`TCK_ALT_BASE << (psSel - 3'h1)) - `TCK_BIN_BASE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         preCnt_r <= '0;
         stepOut_r <= 1'b0;
      end else if (clear || psSel == `TCK_PS_OFF) begin
         preCnt_r <= '0;
         stepOut_r <= 1'b0;
      end else if (srcTick) begin
         if (preCnt_r == termCnt) begin
            preCnt_r <= '0;
            stepOut_r <= 1'b1;
         end else begin
            preCnt_r <= preCnt_r + 1'b1;
            stepOut_r <= 1'b0;
         end
      end else begin
         stepOut_r <= 1'b0;
      end
   end

   assign stepOut = stepOut_r;

endmodule

/* File: verilog/tck_periodic_counter.sv */
// periodic tick counter with apb registers, prescaler and toggle pin
//
// Function
// - on a match with the limit, next step returns count to zero, sets flag
// - a zero limit sets the flag on every prescaler output step
// - reset: counter zero and stopped, limit zero, prescaler off, crystal
// - count register is read only; writes ignored; both bytes read at one instant
// - changed source or prescale code clears prescaler and counter
// - prescale code zero stops everything; nonzero starts the prescaler
// - source codes: crystal, low power, internal reference, bus clock
// - crystal and reference divide by 1, 2, 4 ... 64
// - low power and bus divide by 128 ... 2048, then 100 and 1000
// - counter steps once per prescaler period, wraps and keeps running
// - flag sets on the step from limit to zero
// - new limit reaches comparator at wrap or nonzero prescale write
// - interrupt request follows flag while interrupt enable is set
// - writing one clears flag and request; zero leaves it
// - with toggle enable set, pin inverts at each wrap
// - upper halves of limit and count registers read zero
// - prescale select at status bits 10 to 8, read write, reset 000
// - tick flag at status bit 7, reset zero
// - interrupt enable at status bit 6, read write, reset zero
// - toggle enable at status bit 4, read write
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`include "tck_defines.svh"
module tck_periodic_counter (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`TCK_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic xtalClkPin,
   input wire logic lowPwrClkPin,
   input wire logic irefClkPin,
   output logic tickIrq,
   output logic toggleOut
);
   import tck_pkg::*;

   ////////////////////////////////////////////////////////////
   // register state

   tck_src_e srcSel_r;
   tck_ps_t psSel_r;
   logic flag_r;
   logic irqEn_r;
   logic toggleEn_r;
   tck_count_t limitReg_r;
   tck_count_t limitAct_r;
   tck_count_t count_r;
   logic toggle_r;
   logic irq_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;

   ////////////////////////////////////////////////////////////
   // apb decode

   logic apbAccess;
   logic apbWrite;
   logic apbReadFirst;
   logic addrHit;
   logic scWr;
   logic limitWr;
   tck_src_e newSrc;
   tck_ps_t newPs;
   logic cfgChange;

   // access is taken on the second access-phase cycle, when pready is high
   assign apbAccess = psel & penable & pready_r;
   assign apbWrite = apbAccess & pwrite;
   assign apbReadFirst = psel & penable & ~pready_r & ~pwrite;

   assign addrHit = (paddr == `TCK_SC_OFS) ||
                    (paddr == `TCK_LIMIT_OFS) ||
                    (paddr == `TCK_COUNT_OFS);

   assign scWr = apbWrite && (paddr == `TCK_SC_OFS);
   assign limitWr = apbWrite && (paddr == `TCK_LIMIT_OFS);

   assign newSrc = tck_src_e'(pwdata[`TCK_SRC_HI:`TCK_SRC_LO]);
   assign newPs = pwdata[`TCK_PS_HI:`TCK_PS_LO];

   // a different source or prescale code restarts the time base
   assign cfgChange = scWr && ((newSrc != srcSel_r) ||
                               (newPs != psSel_r));

   ////////////////////////////////////////////////////////////
   // source clock selection

   logic [2:0] pinRise;
   logic srcTick;
   logic altDiv;
   logic step;
   logic wrap;

   // pin clocks pass two flops before the edge detector
   tck_edge_sync u_sync (
      .clk(clk),
      .rst_b(rst_b),
      .pinIn({irefClkPin, lowPwrClkPin, xtalClkPin}),
      .risePulse(pinRise)
   );

   always_comb begin
      srcTick = 1'b0;
      unique case (srcSel_r)
         TCK_SRC_XTAL: srcTick = pinRise[0];
         TCK_SRC_LOWPWR: srcTick = pinRise[1];
         TCK_SRC_IREF: srcTick = pinRise[2];
         TCK_SRC_BUS: srcTick = 1'b1;
      endcase
   end

   // low power and bus sources use the long divider set
   assign altDiv = srcSel_r[0];

   tck_prescaler u_pre (
      .clk(clk),
      .rst_b(rst_b),
      .srcTick(srcTick),
      .clear(cfgChange),
      .altDiv(altDiv),
      .psSel(psSel_r),
      .stepOut(step)
   );

   // a step at the limit value returns to zero
   assign wrap = step && !cfgChange && (psSel_r != `TCK_PS_OFF) &&
                 (count_r == limitAct_r);

   ////////////////////////////////////////////////////////////
   // status and control fields

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         srcSel_r <= TCK_SRC_XTAL;
         psSel_r <= `TCK_PS_OFF;
      end else if (scWr) begin
         srcSel_r <= newSrc;
         psSel_r <= newPs;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irqEn_r <= 1'b0;
         toggleEn_r <= 1'b0;
      end else if (scWr) begin
         irqEn_r <= pwdata[`TCK_IE_BIT];
         toggleEn_r <= pwdata[`TCK_TOE_BIT];
      end
   end

   // a wrap in the clearing cycle wins
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         flag_r <= 1'b0;
      end else if (wrap) begin
         flag_r <= 1'b1;
      end else if (scWr && pwdata[`TCK_FLAG_BIT]) begin
         flag_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////
   // compare limit

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         limitReg_r <= `TCK_LIMIT_RST;
      end else if (limitWr) begin
         limitReg_r <= pwdata[15:0];
      end
   end

   // comparator copy only moves at a wrap or a nonzero prescale write
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         limitAct_r <= `TCK_LIMIT_RST;
      end else if (wrap || (scWr && newPs != `TCK_PS_OFF)) begin
         limitAct_r <= limitReg_r;
      end
   end

   ////////////////////////////////////////////////////////////
   // counter

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         count_r <= `TCK_COUNT_RST;
      end else if (cfgChange || psSel_r == `TCK_PS_OFF) begin
         count_r <= `TCK_COUNT_RST;
      end else if (wrap) begin
         count_r <= `TCK_COUNT_RST;
      end else if (step) begin
         count_r <= count_r + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////
   // toggle pin and interrupt request

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         toggle_r <= 1'b0;
      end else if (wrap && toggleEn_r) begin
         toggle_r <= ~toggle_r;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= flag_r & irqEn_r;
      end
   end

   ////////////////////////////////////////////////////////////
   // apb answer

   // one wait state: pready rises on the second access cycle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pready_r <= 1'b0;
      end else begin
         pready_r <= psel & penable & ~pready_r;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pslverr_r <= 1'b0;
      end else begin
         pslverr_r <= psel & penable & ~pready_r & ~addrHit;
      end
   end

   // word read returns both bytes of one instant
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prdata_r <= 32'h0000_0000;
      end else if (apbReadFirst) begin
         prdata_r <= 32'h0000_0000;
         unique case (paddr)
            `TCK_SC_OFS: begin
               prdata_r[`TCK_SRC_HI:`TCK_SRC_LO] <= srcSel_r;
               prdata_r[`TCK_PS_HI:`TCK_PS_LO] <= psSel_r;
               prdata_r[`TCK_FLAG_BIT] <= flag_r;
               prdata_r[`TCK_IE_BIT] <= irqEn_r;
               prdata_r[`TCK_TOE_BIT] <= toggleEn_r;
            end
            `TCK_LIMIT_OFS: begin
               prdata_r[15:0] <= limitReg_r;
            end
            `TCK_COUNT_OFS: begin
               prdata_r[15:0] <= count_r;
            end
            default: begin
               prdata_r <= 32'h0000_0000;
            end
         endcase
      end else if (!psel) begin
         prdata_r <= 32'h0000_0000;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign tickIrq = irq_r;
   assign toggleOut = toggle_r;

endmodule

/* File: tb/tck_periodic_counter_chk.sv */
// port assertions for the tick counter
`timescale 1ns/1ps
`include "tck_defines.svh"
module tck_periodic_counter_chk (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`TCK_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic xtalClkPin,
   input wire logic lowPwrClkPin,
   input wire logic irefClkPin,
   input wire logic tickIrq,
   input wire logic toggleOut
);
   logic xfer;
   logic rdSc;
   logic [2:0] psSh;
   logic ieSh;
   logic toeSh;
   assign xfer = psel && penable && pready;
   assign rdSc = xfer && !pwrite && paddr == `TCK_SC_OFS;
   ////////////////////////////////////////////////////////////////////////
   // mirror of the prescale and enable fields written over the bus
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         psSh <= 3'h0;
         ieSh <= 1'b0;
         toeSh <= 1'b0;
      end else if (xfer && pwrite && paddr == `TCK_SC_OFS) begin
         psSh <= pwdata[10:8];
         ieSh <= pwdata[6];
         toeSh <= pwdata[4];
      end
   end
   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   a_limit_hi_zero: assert property (
      xfer && !pwrite && paddr == `TCK_LIMIT_OFS |-> prdata[31:16] == 16'h0)
      else $error("limit upper half not zero");
   a_count_hi_zero: assert property (
      xfer && !pwrite && paddr == `TCK_COUNT_OFS |-> prdata[31:16] == 16'h0)
      else $error("count upper half not zero");
   a_ps_readback: assert property (
      rdSc |-> prdata[10:8] == psSh)
      else $error("prescale field readback wrong");
   a_en_readback: assert property (
      rdSc |-> prdata[6] == ieSh && prdata[4] == toeSh)
      else $error("enable bits readback wrong");
   a_irq_needs_en: assert property (
      tickIrq |-> $past(ieSh))
      else $error("interrupt without enable");
   a_toggle_needs_en: assert property (
      $changed(toggleOut) |-> $past(toeSh))
      else $error("toggle without enable");
   a_stop_no_toggle: assert property (
      $changed(toggleOut) |-> $past(psSh) != 3'h0 || $past(psSh, 2) != 3'h0)
      else $error("toggle while prescaler off");
   a_irq_on_wrap: assert property (
      $changed(toggleOut) && $past(ieSh) && ieSh |=> tickIrq)
      else $error("wrap without interrupt");
   a_reset_quiet: assert property (
      $past(rst_b) == 1'b0 |-> !tickIrq && !toggleOut)
      else $error("outputs active after reset");
   c_toggle: cover property ($changed(toggleOut));
   c_irq: cover property ($rose(tickIrq));
   c_slverr: cover property (pslverr);
endmodule

bind tck_periodic_counter tck_periodic_counter_chk u_tck_periodic_counter_chk (
   .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .xtalClkPin(xtalClkPin),
   .lowPwrClkPin(lowPwrClkPin), .irefClkPin(irefClkPin),
   .tickIrq(tickIrq), .toggleOut(toggleOut)
);

/* File: tb/tck_periodic_counter_tb.sv */
// self-checking bench for the tick counter
`timescale 1ns/1ps
`include "tck_defines.svh"
module tck_periodic_counter_tb;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [`TCK_ADDR_W-1:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [2:0] pin = 3'h0;
   logic tickIrq;
   logic toggleOut;
   logic [31:0] rd;
   logic err;
   int failures = 0;
   int samples_checked = 0;

   always #10 clk = ~clk;
   // source pins rise every fourth clock
   always begin
      repeat (2) @(posedge clk);
      pin <= ~pin;
   end

   tck_periodic_counter u_tck_periodic_counter (
      .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .xtalClkPin(pin[0]),
      .lowPwrClkPin(pin[1]), .irefClkPin(pin[2]), .tickIrq(tickIrq),
      .toggleOut(toggleOut)
   );
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic final_report();
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // one transfer, entered just after an edge, idle cycle after it
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      for (int i = 0; i < 3; i++) begin
         apb(1'b0, 8'(i * 4), 32'h0);
         check(rd, 32'h0);
      end
   endtask

   task automatic t_regs();
      apb(1'b1, `TCK_LIMIT_OFS, 32'hffff1234);
      apb(1'b0, `TCK_LIMIT_OFS, 32'h0);
      check(rd, 32'h1234);
      apb(1'b1, `TCK_COUNT_OFS, 32'hffffffff);
      apb(1'b0, `TCK_COUNT_OFS, 32'h0);
      check(rd, 32'h0);
      apb(1'b1, `TCK_SC_OFS, 32'h50);
      apb(1'b0, `TCK_SC_OFS, 32'h0);
      check(rd, 32'h50);
      apb(1'b0, 8'h0c, 32'h0);
      check({31'h0, err}, 32'h1);
   endtask

   // zero limit: toggle half period equals the prescaler period in clocks
   task automatic t_rate(input logic [1:0] s, input logic [2:0] p,
                         input int per);
      int n;
      logic last;
      apb(1'b1, `TCK_SC_OFS, {16'h0, s, 3'h0, p, 8'h50});
      repeat (8) @(posedge clk);
      for (int k = 0; k < 2; k++) begin
         last = toggleOut;
         n = 0;
         do begin
            @(posedge clk);
            n++;
         end while (toggleOut === last && n < 20000);
      end
      check(32'(n), 32'(per));
   endtask

   task automatic t_rates();
      int bin[7] = '{1, 2, 4, 8, 16, 32, 64};
      int alt[7] = '{128, 256, 512, 1024, 2048, 100, 1000};
      apb(1'b1, `TCK_LIMIT_OFS, 32'h0);
      for (int s = 0; s < 4; s++) begin
         for (int p = 1; p < 8; p++) begin
            t_rate(2'(s), 3'(p), s == 3 ? alt[p-1] :
                   (s == 1 ? alt[p-1] * 4 : bin[p-1] * 4));
         end
      end
   endtask

   // bus source divided by 1000, one step per 1000 clocks
   task automatic t_count();
      apb(1'b1, `TCK_SC_OFS, 32'h80);
      apb(1'b0, `TCK_SC_OFS, 32'h0);
      check(rd, 32'h0);
      apb(1'b1, `TCK_LIMIT_OFS, 32'h5);
      apb(1'b1, `TCK_SC_OFS, 32'hc740);
      repeat (2500) @(posedge clk);
      apb(1'b0, `TCK_COUNT_OFS, 32'h0);
      check(rd, 32'h2);
      apb(1'b1, `TCK_LIMIT_OFS, 32'h1);
      repeat (1000) @(posedge clk);
      apb(1'b0, `TCK_COUNT_OFS, 32'h0);
      check(rd, 32'h3);
      repeat (2000) @(posedge clk);
      apb(1'b0, `TCK_SC_OFS, 32'h0);
      check(rd, 32'hc740);
      repeat (1000) @(posedge clk);
      apb(1'b0, `TCK_SC_OFS, 32'h0);
      check(rd, 32'hc7c0);
      check({31'h0, tickIrq}, 32'h1);
      apb(1'b1, `TCK_SC_OFS, 32'hc740);
      apb(1'b0, `TCK_SC_OFS, 32'h0);
      check(rd, 32'hc7c0);
      apb(1'b1, `TCK_SC_OFS, 32'hc7c0);
      apb(1'b0, `TCK_SC_OFS, 32'h0);
      check(rd, 32'hc740);
      check({31'h0, tickIrq}, 32'h0);
      repeat (1000) @(posedge clk);
      apb(1'b0, `TCK_COUNT_OFS, 32'h0);
      check(rd, 32'h1);
      repeat (1000) @(posedge clk);
      apb(1'b0, `TCK_COUNT_OFS, 32'h0);
      check(rd, 32'h0);
      repeat (1000) @(posedge clk);
      apb(1'b1, `TCK_SC_OFS, 32'hc640);
      apb(1'b0, `TCK_COUNT_OFS, 32'h0);
      check(rd, 32'h0);
      apb(1'b1, `TCK_SC_OFS, 32'h0);
      repeat (500) @(posedge clk);
      apb(1'b0, `TCK_COUNT_OFS, 32'h0);
      check(rd, 32'h0);
   endtask

   // reset while counting returns every field to its reset value
   task automatic t_midreset();
      apb(1'b1, `TCK_SC_OFS, 32'hc750);
      repeat (1500) @(posedge clk);
      rst_b <= 1'b0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      check({30'h0, tickIrq, toggleOut}, 32'h0);
      t_reset();
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (90000) @(posedge clk);
      failures++;
      $display("ERROR %0t: watchdog expired", $time);
      final_report();
   end

   initial begin
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      t_reset();
      t_regs();
      t_rates();
      t_count();
      t_midreset();
      final_report();
   end
endmodule
